/* rtl/reset_strap_config_select.sv */
// Captures general-purpose pin straps at master reset release
//
// Behaviour
// - Capture every pin at master reset release; settings come from that capture or a later write.
// - Captured pin 9 low selects SPI, high selects I2C on the auxiliary port.
// - With no select pins assigned, pins 3 to 0 form the index.
// - All four default select pins high selects stored configuration 15.
// - Every pin has a pull-up, so an undriven strap reads one.
// - Lowest assigned select pin is the index LSB, rising in pin order.
// - Fewer than four select pins fill low bits; upper bits are zero.
// - More than four select pins give a wider index.
// - Select, EEPROM-disable and address-bit pin functions come only from the factory device information block; pins 9 and 8 are fixed.
// - Unprogrammed parts ignore select straps and use default strap behaviour.
// - A high captured EEPROM-disable pin stops the start-up EEPROM reads.
// - With no EEPROM-disable pin, the EEPROM search always runs.
// - Any active EEPROM-disable pin among several suppresses the search.
// - With no address-bit pin, slave address bit two is zero.
// - Several address-bit pins: only the highest-numbered one counts.
// - The address-bit strap applies only when the port is I2C.
// - Strap-derived values stay writable by configuration load or host.
// - Without stored configuration, clock outputs off and pins are inputs.
// - Initial configuration comes from straps, stored memory, EEPROM and defaults.
// - A failing checksum on the chosen configuration keeps register defaults.
`timescale 1ns/1ns
`default_nettype none
`include "strap_cfg.svh"
module reset_strap_config_select
  import strap_pkg::*;
(
  // Clock and master reset
  input  wire logic                 clk_sys,
  input  wire logic                 arst_n,
  input  wire logic                 master_reset_low_n,
  // Pins from the board
  input  wire logic [15:0]          gpio_pin_in,
  // Pull-up enables, always on after reset
  output logic      [15:0]          gpio_pullup_en,
  // Pin functions from the device information block
  input  wire pin_map_type          pin_map,
  input  wire logic                 pin_map_valid,
  // Stored configuration load result
  input  wire logic                 cfg_load_done,
  input  wire logic                 cfg_checksum_ok,
  // Overwrite path from configuration load or host
  input  wire logic                 settings_wr,
  input  wire strap_settings_type   settings_wdata,
  // Derived settings
  output strap_settings_type        settings,
  output logic                      straps_valid,
  output logic                      pin8_fault,
  output logic                      use_stored_cfg,
  output logic                      clk_out_en,
  output logic      [15:0]          gpio_as_input
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [15:0] pin_meta_q;
  logic [15:0] pin_sync_q;
  logic        mr_meta_q;
  logic        mr_sync_q;
  logic        mr_prev_q;

  // Pins reset to the pull-up level so no strap looks driven low
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pin_meta_q <= `STRAP_PIN_RESET;
      pin_sync_q <= `STRAP_PIN_RESET;
    end else begin
      pin_meta_q <= gpio_pin_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  // Master reset resets to held, so a pin already released at
  // power-up still gives one rising edge to capture on
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mr_meta_q <= 1'b0;
      mr_sync_q <= 1'b0;
      mr_prev_q <= 1'b0;
    end else begin
      mr_meta_q <= master_reset_low_n;
      mr_sync_q <= mr_meta_q;
      mr_prev_q <= mr_sync_q;
    end
  end

  // Pin and reset pass the same two stages, so the capture is aligned
  wire mr_rise = mr_sync_q && !mr_prev_q;
  // Held phase of master reset, seen through the same two stages
  wire mr_held = !mr_sync_q;

  ////////////////////////////////////////////////////////////////////////////
  // Capture sequence
  strap_state_type state_q;
  strap_state_type state_d;
  logic [15:0]     cap_q;
  logic            pin8_fault_q;
  logic            pin8_fault_d;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RESET: begin
        // Arm only once the pin has been seen held
        state_d = mr_held ? ST_SYNC : ST_RESET;
      end
      ST_SYNC: begin
        state_d = mr_rise ? ST_CAPTURE : ST_SYNC;
      end
      ST_CAPTURE: begin
        // One cycle for the map and the packing to settle
        state_d = ST_HOLD;
      end
      ST_HOLD: begin
        // A new hold of master reset re-arms the capture
        state_d = mr_held ? ST_SYNC : ST_HOLD;
      end
      default: begin
        state_d = ST_RESET;
      end
    endcase
  end

  // Low pin 8 while reset is held is flagged, not acted upon
  wire pin8_low_held = mr_held && !pin_sync_q[`STRAP_HOLD_HIGH_PIN];
  // Raising the flag wins over the clear at the release edge
  always_comb begin
    if (pin8_low_held) begin
      pin8_fault_d = 1'b1;
    end else if (mr_rise) begin
      pin8_fault_d = 1'b0;
    end else begin
      pin8_fault_d = pin8_fault_q;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pin8_fault_q <= 1'b0;
    end else begin
      pin8_fault_q <= pin8_fault_d;
    end
  end

  // Capture only on the release edge; later pin activity is ignored
  wire [15:0] cap_d = mr_rise ? pin_sync_q : cap_q;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cap_q <= `STRAP_PIN_RESET;
    end else begin
      cap_q <= cap_d;
    end
  end

  assign pin8_fault = pin8_fault_q;
  assign gpio_pullup_en = `STRAP_PIN_RESET;

  ////////////////////////////////////////////////////////////////////////////
  // Function map
  // An unprogrammed or absent map means every strap uses its default
  wire         map_used   = pin_map_valid && !pin_map.unprogrammed;
  wire [15:0]  sel_mask   = map_used ? pin_map.sel_mask : 16'h0000;
  wire [15:0]  dis_mask   = map_used ? pin_map.eeprom_dis_mask : 16'h0000;
  wire [15:0]  addr_mask  = map_used ? pin_map.addr_bit_mask : 16'h0000;
  wire         sel_none   = (sel_mask == 16'h0000);
  wire [15:0]  def_mask   = 16'h000F << `STRAP_DEF_SEL_LSB;
  wire [15:0]  eff_sel    = sel_none ? def_mask : sel_mask;

  ////////////////////////////////////////////////////////////////////////////
  // Index packing
  logic [15:0] packed_index;

  // Any count of pins packs densely; four defaults all high give 15
  strap_index_pack u_pack (
    .pins  (cap_q),
    .mask  (eff_sel),
    .index (packed_index)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Address bit: highest assigned pin wins
  logic [16:0] addr_hit;
  logic [16:0] addr_val;
  assign addr_hit[0] = 1'b0;
  assign addr_val[0] = 1'b0;
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_addr
      assign addr_hit[g+1] = addr_hit[g] | addr_mask[g];
      assign addr_val[g+1] = addr_mask[g] ? cap_q[g] : addr_val[g];
    end
  endgenerate

  wire port_i2c = cap_q[`STRAP_PORT_SEL_PIN];
  // No assigned pin or SPI port leaves the bit at zero
  wire addr_bit = port_i2c && addr_hit[16] && addr_val[16];
  // Any active disable pin stops the search; none leaves it on
  wire eeprom_off = |(dis_mask & cap_q);

  strap_settings_type derived;
  assign derived.port_is_i2c        = port_i2c;
  assign derived.slave_addr_bit_two = addr_bit;
  assign derived.eeprom_search_en   = !eeprom_off;
  assign derived.stored_config_set  = packed_index;

  ////////////////////////////////////////////////////////////////////////////
  // Settings register
  strap_settings_type settings_q;
  strap_settings_type settings_d;
  logic               valid_q;
  logic               valid_d;
  logic               load_q;
  logic               load_d;

  // Derivation waits one cycle after capture so the map settles.
  // Straps win over a write in that cycle; the write is lost there,
  // a limitation accepted to keep the capture atomic.
  wire take_capture = (state_q == ST_CAPTURE);
  wire take_write   = settings_wr && !take_capture;

  always_comb begin
    if (take_capture) begin
      settings_d = derived;
    end else if (take_write) begin
      settings_d = settings_wdata;
    end else begin
      settings_d = settings_q;
    end
  end

  // Valid rises at the first capture and then stays
  assign valid_d = valid_q || take_capture;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      settings_q <= '{port_is_i2c: 1'b1, slave_addr_bit_two: 1'b0,
                      eeprom_search_en: 1'b1,
                      stored_config_set: `STRAP_INDEX_RESET};
    end else begin
      settings_q <= settings_d;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= valid_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stored configuration result
  // A good checksum selects the stored set; a bad one keeps defaults.
  // A result in the capture cycle is dropped along with the old straps.
  always_comb begin
    if (take_capture) begin
      load_d = 1'b0;
    end else if (cfg_load_done) begin
      load_d = cfg_checksum_ok;
    end else begin
      load_d = load_q;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      load_q <= 1'b0;
    end else begin
      load_q <= load_d;
    end
  end

  assign settings       = settings_q;
  assign straps_valid   = valid_q;
  assign use_stored_cfg = load_q;
  // Defaults without a stored configuration: outputs off, pins as inputs
  assign clk_out_en     = load_q;
  assign gpio_as_input  = load_q ? 16'h0000 : 16'hFFFF;

endmodule
`default_nettype wire

/* rtl/strap_cfg.svh */
// Constants for the reset strap capture block
`ifndef STRAP_CFG_SVH
`define STRAP_CFG_SVH
`define STRAP_GPIO_COUNT     16
`define STRAP_PORT_SEL_PIN   9
`define STRAP_HOLD_HIGH_PIN  8
`define STRAP_DEF_SEL_LSB    0
`define STRAP_SEL_MIN_WIDTH  4
`define STRAP_PIN_RESET      16'hFFFF
`define STRAP_INDEX_RESET    16'h000F
`define STRAP_CAPTURE_DELAY  2
`endif

/* rtl/strap_index_pack.sv */
// Packs masked captured pins into a dense selection index
`timescale 1ns/1ns
`default_nettype none
module strap_index_pack
  import strap_pkg::*;
(
  // Captured pins and the selection mask
  input  wire logic [15:0] pins,
  input  wire logic [15:0] mask,
  // Packed index, lowest assigned pin at bit 0
  output logic      [15:0] index
);
  // Prefix count of assigned pins below each pin gives its index bit
  logic [4:0] pos [0:16];
  logic [15:0] part [0:16];
  assign pos[0] = 5'd0;
  assign part[0] = 16'h0000;
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_pack
      assign pos[g+1] = pos[g] + {4'h0, mask[g]};
      assign part[g+1] = part[g] |
        ((mask[g] && pins[g]) ? (16'h0001 << pos[g][3:0]) : 16'h0000);
    end
  endgenerate
  // Unfilled upper bits stay zero
  assign index = part[16];
endmodule
`default_nettype wire

/* rtl/strap_pkg.sv */
// Types shared by the reset strap capture block
package strap_pkg;
  typedef enum logic [1:0] {
    ST_RESET   = 2'b00,
    ST_SYNC    = 2'b01,
    ST_CAPTURE = 2'b11,
    ST_HOLD    = 2'b10
  } strap_state_type;

  // Pin function map from the device information block
  typedef struct packed {
    logic        unprogrammed;
    logic [15:0] sel_mask;
    logic [15:0] eeprom_dis_mask;
    logic [15:0] addr_bit_mask;
  } pin_map_type;

  // Settings derived from the straps
  typedef struct packed {
    logic        port_is_i2c;
    logic        slave_addr_bit_two;
    logic        eeprom_search_en;
    logic [15:0] stored_config_set;
  } strap_settings_type;
endpackage

/* verif/reset_strap_config_select_chk.sv */
// Checker for the reset strap capture block
`timescale 1ns/1ns
`default_nettype none
module reset_strap_config_select_chk
  import strap_pkg::*;
(
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               arst_n,
  // Watched ports
  input  wire logic               master_reset_low_n,
  input  wire logic [15:0]        gpio_pullup_en,
  input  wire pin_map_type        pin_map,
  input  wire logic               pin_map_valid,
  input  wire logic               cfg_load_done,
  input  wire logic               cfg_checksum_ok,
  input  wire logic               settings_wr,
  input  wire strap_settings_type settings_wdata,
  input  wire strap_settings_type settings,
  input  wire logic               straps_valid,
  input  wire logic               use_stored_cfg,
  input  wire logic               clk_out_en,
  input  wire logic [15:0]        gpio_as_input
);
  logic [3:0] settle_q;
  // Capture and derive are long over once this saturates
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n) settle_q <= 4'h0;
    else if (!master_reset_low_n) settle_q <= 4'h0;
    else if (settle_q != 4'hf) settle_q <= settle_q + 4'h1;
  wire quiet = (settle_q == 4'hf);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  a_pullup_always_on: assert property (gpio_pullup_en == 16'hffff)
    else $error("pull-ups off");
  a_release_gives_valid: assert property ($rose(master_reset_low_n) |-> ##[2:6] straps_valid)
    else $error("no straps after release");
  a_spi_drops_addr: assert property ($changed(settings) && !$past(settings_wr) |->
    settings.port_is_i2c || !settings.slave_addr_bit_two) else $error("address bit on spi");
  a_unprog_defaults: assert property ($changed(settings) && !$past(settings_wr) &&
    (pin_map.unprogrammed || !pin_map_valid) |-> settings.eeprom_search_en &&
    settings.stored_config_set[15:4] == 12'h000) else $error("default straps ignored");
  a_write_replaces: assert property (quiet && settings_wr |=> settings == $past(settings_wdata))
    else $error("write lost");
  a_settings_hold: assert property (quiet && !settings_wr |=> $stable(settings))
    else $error("settings drifted");
  a_bad_sum_default: assert property (quiet && cfg_load_done && !cfg_checksum_ok |=> !use_stored_cfg)
    else $error("bad checksum loaded");
  a_good_sum_loads: assert property (quiet && cfg_load_done && cfg_checksum_ok |=> use_stored_cfg)
    else $error("good load ignored");
  a_default_outputs_off: assert property (!use_stored_cfg && !$past(use_stored_cfg) |->
    !clk_out_en && gpio_as_input == 16'hffff) else $error("defaults not neutral");
  c_release: cover property ($rose(master_reset_low_n));
  c_write: cover property (quiet && settings_wr);
  c_good_load: cover property (quiet && cfg_load_done && cfg_checksum_ok);
endmodule
bind reset_strap_config_select reset_strap_config_select_chk chk (.*);
`default_nettype wire

/* verif/reset_strap_config_select_test.sv */
// Self-checking testbench for the reset strap capture block
`timescale 1ns/1ns
`default_nettype none
module reset_strap_config_select_test
  import strap_pkg::*;
;
  typedef struct packed {
    logic               pv;
    pin_map_type        map;
    logic [15:0]        pins;
    strap_settings_type exp;
  } row_type;
  logic               clk_sys = 1'b0, arst_n = 1'b0, mr_n = 1'b0, pv = 1'b0, hold8 = 1'b1;
  logic               ld = 1'b0, ok = 1'b0, wr = 1'b0, valid, fault, use_cfg, clk_en;
  logic [15:0]        drv_en = 16'h0000, pins, pull_en, as_in;
  pin_map_type        map = '0;
  strap_settings_type wdata = '0, set;
  int                 mismatches = 0, checked = 0, cycles = 0;
  row_type            rows [9];

  always #50 clk_sys = ~clk_sys;
  strap_board board (.drv_en(drv_en), .pullup_en(pull_en), .mr_n(mr_n),
    .pin8_hold(hold8), .pins(pins));
  reset_strap_config_select uut (.clk_sys(clk_sys), .arst_n(arst_n), .master_reset_low_n(mr_n),
    .gpio_pin_in(pins), .gpio_pullup_en(pull_en), .pin_map(map), .pin_map_valid(pv),
    .cfg_load_done(ld), .cfg_checksum_ok(ok), .settings_wr(wr), .settings_wdata(wdata),
    .settings(set), .straps_valid(valid), .pin8_fault(fault), .use_stored_cfg(use_cfg),
    .clk_out_en(clk_en), .gpio_as_input(as_in));

  task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 1000) begin
      mismatches++;
      summarize();
    end
  end
  task automatic strap(input row_type r);
    mr_n <= 1'b0;
    drv_en <= ~r.pins;
    map <= r.map;
    pv <= r.pv;
    repeat (4) @(posedge clk_sys);
    mr_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    // Flip every strap after release; settings must not follow
    drv_en <= r.pins;
    repeat (6) @(posedge clk_sys);
  endtask

  initial begin
    rows[0] = '{1'b0, '0, 16'hffff, '{1'b1, 1'b0, 1'b1, 16'h000f}};
    rows[1] = '{1'b1, '0, 16'hfdfa, '{1'b0, 1'b0, 1'b1, 16'h000a}};
    rows[2] = '{1'b1, '{1'b0, 16'h0164, 16'h0000, 16'h0000}, 16'h0344, '{1'b1, 1'b0, 1'b1, 16'h000d}};
    rows[3] = '{1'b1, '{1'b0, 16'h0030, 16'h0081, 16'h0000}, 16'h0321, '{1'b1, 1'b0, 1'b0, 16'h0002}};
    rows[4] = '{1'b1, '{1'b0, 16'h0000, 16'h0000, 16'h00a0}, 16'h0320, '{1'b1, 1'b0, 1'b1, 16'h0000}};
    rows[5] = '{1'b1, '{1'b0, 16'h0000, 16'h0000, 16'h00a0}, 16'h0380, '{1'b1, 1'b1, 1'b1, 16'h0000}};
    rows[6] = '{1'b1, '{1'b0, 16'h0000, 16'h0000, 16'h00a0}, 16'h0180, '{1'b0, 1'b0, 1'b1, 16'h0000}};
    rows[7] = '{1'b1, '{1'b0, 16'h003f, 16'h0000, 16'h0000}, 16'h0325, '{1'b1, 1'b0, 1'b1, 16'h0025}};
    rows[8] = '{1'b1, '{1'b1, 16'h0030, 16'h0001, 16'h0080}, 16'h038b, '{1'b1, 1'b0, 1'b1, 16'h000b}};
    repeat (5) @(posedge clk_sys);
    cmp({valid, clk_en, use_cfg, fault}, 4'h0);
    cmp(as_in, 16'hffff);
    cmp(set, {3'b101, 16'h000f});
    arst_n <= 1'b1;
    foreach (rows[i]) begin
      strap(rows[i]);
      cmp(set, rows[i].exp);
      cmp({valid, fault}, 2'b10);
    end
    // Board breaks the pin 8 rule: the part flags it while held
    hold8 <= 1'b0;
    drv_en <= 16'h0100;
    mr_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    cmp(fault, 1'b1);
    hold8 <= 1'b1;
    drv_en <= 16'h0000;
    mr_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    cmp(fault, 1'b0);
    // Long enough for the checker's settle counter to saturate
    repeat (16) @(posedge clk_sys);
    cmp(set, {3'b101, 16'h000f});
    wdata <= '{1'b0, 1'b0, 1'b0, 16'h0123};
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
    repeat (2) @(posedge clk_sys);
    cmp(set, {3'b000, 16'h0123});
    ld <= 1'b1;
    @(posedge clk_sys);
    ld <= 1'b0;
    repeat (2) @(posedge clk_sys);
    cmp({use_cfg, clk_en, as_in}, {2'b00, 16'hffff});
    ld <= 1'b1;
    ok <= 1'b1;
    @(posedge clk_sys);
    ld <= 1'b0;
    repeat (2) @(posedge clk_sys);
    cmp({use_cfg, clk_en}, 2'b11);
    summarize();
  end
endmodule
`default_nettype wire

/* verif/strap_board.sv */
// Board model: open-drain straps over the part's pin pull-ups
`timescale 1ns/1ns
`default_nettype none
module strap_board (
  // Straps that pull a pin low, and the part's pull-up enables
  input  wire logic [15:0] drv_en,
  input  wire logic [15:0] pullup_en,
  input  wire logic        mr_n,
  // Board keeps pin 8 high during reset when set
  input  wire logic        pin8_hold,
  // Levels seen at the part's pins
  output logic      [15:0] pins
);
  // Pin 8 held high by the board while master reset is low and pin8_hold is set
  assign pins = (~drv_en & pullup_en) | {7'h00, ~mr_n & pin8_hold, 8'h00};
endmodule
`default_nettype wire
